// ===== hw/adcsri_pkg.sv
package adcsri_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W     = 24;
  localparam int BIT_CNT_W  = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int RATE_W     = 11;
  localparam int GAIN_W     = 3;
  localparam int CNT_W      = 11;
  localparam int DLY_W      = 2;

  localparam logic [GAIN_W-1:0]    GAIN_ONE = 3'h0;   // gain code for unity gain
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h17;  // index of the last bit of a word

  // ==========================================================
  // modes
  typedef enum logic [1:0] {
    PM_LOW  = 2'h0,
    PM_MID  = 2'h1,
    PM_FULL = 2'h2
  } adcsri_pwr_t;

  typedef enum logic [1:0] {
    CM_CONT      = 2'h0,
    CM_SINGLE    = 2'h1,
    CM_CONT_READ = 2'h2
  } adcsri_conv_t;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int GAP_FULL_MCLK = 3;
  localparam int GAP_MID_MCLK  = 12;
  localparam int GAP_LOW_MCLK  = 24;
  localparam int T13_FULL_US   = 6;
  localparam int T13_MID_US    = 25;
  localparam int T13_LOW_US    = 50;
  localparam int RDY_DLY_NS     = 10;
  localparam int RDY_DLY_EXT_NS = 110;

  localparam int T13_FULL_CYC = (T13_FULL_US * 1000) / CLK_PERIOD_NS;
  localparam int T13_MID_CYC  = (T13_MID_US * 1000) / CLK_PERIOD_NS;
  localparam int T13_LOW_CYC  = (T13_LOW_US * 1000) / CLK_PERIOD_NS;
  localparam logic [DLY_W-1:0] RDY_DLY_CYC =
    DLY_W'((RDY_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] RDY_DLY_EXT_CYC =
    DLY_W'((RDY_DLY_EXT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // least gap and restart width in master clocks, per power mode
  function automatic logic [CNT_W-1:0] min_mclk_cycles(input logic [1:0] pm);
    case (pm)
      PM_LOW:  min_mclk_cycles = CNT_W'(GAP_LOW_MCLK);
      PM_MID:  min_mclk_cycles = CNT_W'(GAP_MID_MCLK);
      default: min_mclk_cycles = CNT_W'(GAP_FULL_MCLK);
    endcase
  endfunction

  // ready high pulse length before a fresh result, per power mode
  function automatic logic [CNT_W-1:0] t13_cycles(input logic [1:0] pm);
    case (pm)
      PM_LOW:  t13_cycles = CNT_W'(T13_LOW_CYC);
      PM_MID:  t13_cycles = CNT_W'(T13_MID_CYC);
      default: t13_cycles = CNT_W'(T13_FULL_CYC);
    endcase
  endfunction

endpackage

// ===== hw/adcsri_fifo_if.sv
`timescale 1ns/100ps
// result stream between the core and its buffer
interface adcsri_fifo_if #(parameter int W = 24);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;

  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

// ===== hw/adcsri_mem.sv
`timescale 1ns/100ps
// small dual-port store, registered read with write bypass
module adcsri_mem #(
  parameter int W  = 24,
  parameter int D  = 16,
  parameter int AW = 4
) (
  input  wire logic          clk_sys,  // system clock
  input  wire logic          we,       // write strobe
  input  wire logic [AW-1:0] waddr,    // write address
  input  wire logic [W-1:0]  wdata,    // write data
  input  wire logic [AW-1:0] raddr,    // read address
  output logic      [W-1:0]  rdata     // registered read data
);
  logic [W-1:0] mem_q [D];

  // write port
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
  end

  // read port; bypass keeps a word written to the read slot visible at once
  always_ff @(posedge clk_sys) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem_q[raddr];
    end
  end
endmodule

// ===== hw/adcsri_fifo.sv
`timescale 1ns/100ps
// result buffer with honest full and empty
module adcsri_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  input wire logic  clk_sys,  // system clock
  input wire logic  resetn,   // synchronous reset, active low
  adcsri_fifo_if.fifo f       // fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  logic [AW:0]   wr_ptr_q;
  logic [AW:0]   rd_ptr_q;
  logic [AW:0]   rd_ptr_d;
  logic          push;
  logic          pop;
  logic          empty;
  logic          full;

  // flags from pointer compare
  assign empty      = (wr_ptr_q == rd_ptr_q);
  assign full       = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign f.wr_ready = !full;
  assign f.rd_valid = !empty;
  assign push       = f.wr_valid && !full;
  assign pop        = f.rd_ready && !empty;
  assign rd_ptr_d   = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;

  // pointer update
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      rd_ptr_q <= rd_ptr_d;
    end
  end

  adcsri_mem #(.W(W), .D(DEPTH), .AW(AW)) u_mem (
    .clk_sys (clk_sys),
    .we      (push),
    .waddr   (wr_ptr_q[AW-1:0]),
    .wdata   (f.wr_data),
    .raddr   (rd_ptr_d[AW-1:0]),
    .rdata   (f.rd_data)
  );
endmodule

// ===== hw/adcsri_top.sv
`timescale 1ns/100ps
// serial result port with shared data-out / ready pin
module adcsri_top (
  input  wire logic                             clk_sys,               // system clock, 20 MHz
  input  wire logic                             resetn,                // sync reset, active low
  input  wire logic                             sclk,                  // serial link clock pin
  input  wire logic                             cs_n,                  // chip select pin
  input  wire logic                             din,                   // serial data in pin
  input  wire logic                             sync_n,                // filter restart pin
  output logic                                  dout_rdy_o,            // shared pin output level
  output logic                                  dout_rdy_oe,           // shared pin drive enable
  input  wire logic [1:0]                       power_mode,            // power mode select
  input  wire logic [1:0]                       conv_mode,             // conversion mode select
  input  wire logic                             hold_until_deselect,   // keep last bit to deselect
  input  wire logic                             ready_delay_extend,    // longer ready delay
  input  wire logic                             res_valid,             // new result offered
  output logic                                  res_ready,             // result buffer has room
  input  wire logic [adcsri_pkg::DATA_W-1:0]    res_data,              // conversion result
  output logic      [adcsri_pkg::DATA_W-1:0]    din_word,              // word shifted in
  output logic                                  din_word_valid,        // pulse on word in
  output logic                                  spacing_error,         // pulse on short gap
  output logic                                  filter_restart,        // pulse on valid restart
  input  wire logic [adcsri_pkg::GAIN_W-1:0]    gain_code,             // programmed gain
  input  wire logic                             buf_disable_req,       // request buffers off
  output logic                                  buf_enable_eff,        // buffers in use
  input  wire logic                             first_notch_50hz,      // first notch at 50 Hz
  input  wire logic                             sixty_hz_notch_select, // add 60 Hz notch
  output logic                                  notch_60_en,           // 60 Hz notch active
  input  wire logic [adcsri_pkg::RATE_W-1:0]    rate_select_field,     // rate select field
  output logic      [adcsri_pkg::RATE_W-1:0]    rate_divider           // filter rate divider
);

  // ==========================================================
  // types and storage
  typedef enum logic [1:0] {
    SER_IDLE  = 2'h0,
    SER_SHIFT = 2'h1,
    SER_HOLD  = 2'h2
  } adcsri_ser_t;

  adcsri_ser_t                          state_q;
  logic [1:0]                           sclk_s_q;
  logic [1:0]                           cs_s_q;
  logic [1:0]                           din_s_q;
  logic [1:0]                           sync_s_q;
  logic                                 sclk_p_q;
  logic                                 cs_p_q;
  logic                                 sclk_fall;
  logic                                 sclk_rise;
  logic                                 cs_fall;
  logic                                 cs_rise;
  logic [adcsri_pkg::DATA_W-1:0]        shift_q;
  logic [adcsri_pkg::DATA_W-1:0]        rx_q;
  logic [adcsri_pkg::BIT_CNT_W-1:0]     bit_cnt_q;
  logic                                 first_q;
  logic                                 rd_done;
  logic [adcsri_pkg::DATA_W-1:0]        word_q;
  logic                                 have_q;
  logic                                 word_new_q;
  logic [adcsri_pkg::CNT_W-1:0]         pulse_cnt_q;
  logic [adcsri_pkg::DLY_W-1:0]         dly_cnt_q;
  logic                                 rdy_level;
  logic                                 load_en;
  logic [adcsri_pkg::CNT_W-1:0]         gap_cnt_q;
  logic [adcsri_pkg::CNT_W-1:0]         sync_cnt_q;

  adcsri_fifo_if #(.W(adcsri_pkg::DATA_W)) fif ();

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sclk_s_q <= 2'h3;
      cs_s_q   <= 2'h3;
      din_s_q  <= 2'h0;
      sync_s_q <= 2'h3;
    end else begin
      sclk_s_q <= {sclk_s_q[0], sclk};
      cs_s_q   <= {cs_s_q[0], cs_n};
      din_s_q  <= {din_s_q[0], din};
      sync_s_q <= {sync_s_q[0], sync_n};
    end
  end

  // previous synchronised levels for edge finding
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sclk_p_q <= 1'b1;
      cs_p_q   <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s_q[1];
      cs_p_q   <= cs_s_q[1];
    end
  end

  assign sclk_fall = sclk_p_q && !sclk_s_q[1];
  assign sclk_rise = !sclk_p_q && sclk_s_q[1];
  assign cs_fall   = cs_p_q && !cs_s_q[1];
  assign cs_rise   = !cs_p_q && cs_s_q[1];
  assign rd_done   = (state_q == SER_SHIFT) && sclk_rise && (bit_cnt_q == adcsri_pkg::LAST_BIT);

  // ==========================================================
  // result buffer
  assign fif.wr_valid = res_valid;
  assign fif.wr_data  = res_data;
  assign res_ready    = fif.wr_ready;
  assign load_en      = fif.rd_valid && (state_q == SER_IDLE) && cs_s_q[1] && (pulse_cnt_q == '0);
  assign fif.rd_ready = load_en;

  adcsri_fifo #(.W(adcsri_pkg::DATA_W), .DEPTH(adcsri_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .f       (fif.fifo)
  );

  // ==========================================================
  // transaction sequencer
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= SER_IDLE;
    end else begin
      case (state_q)
        SER_IDLE: begin
          if (cs_fall) begin
            state_q <= SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          if (cs_rise) begin
            state_q <= SER_IDLE;
          end else if (rd_done) begin
            state_q <= SER_HOLD;
          end
        end
        SER_HOLD: begin
          if (cs_rise) begin
            state_q <= SER_IDLE;
          end
        end
        default: state_q <= SER_IDLE;
      endcase
    end
  end

  // output shifter: moves on the falling link edge
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      shift_q   <= '0;
      bit_cnt_q <= '0;
      first_q   <= 1'b0;
    end else if ((state_q == SER_IDLE) && cs_fall) begin
      shift_q   <= have_q ? word_q : '0;
      bit_cnt_q <= '0;
      first_q   <= 1'b1;
    end else if (state_q == SER_SHIFT) begin
      if (sclk_fall) begin
        first_q <= 1'b0;
        if (!first_q) begin
          shift_q <= {shift_q[adcsri_pkg::DATA_W-2:0], 1'b0};
        end
      end
      if (sclk_rise) begin
        bit_cnt_q <= bit_cnt_q + 1'b1;
      end
    end
  end

  // input capture on the rising edge after the falling edge set up the bit
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rx_q           <= '0;
      din_word       <= '0;
      din_word_valid <= 1'b0;
    end else begin
      din_word_valid <= rd_done;
      if ((state_q == SER_SHIFT) && sclk_rise) begin
        rx_q <= {rx_q[adcsri_pkg::DATA_W-2:0], din_s_q[1]};
      end
      if (rd_done) begin
        din_word <= {rx_q[adcsri_pkg::DATA_W-2:0], din_s_q[1]};
      end
    end
  end

  // ==========================================================
  // result word and ready state
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      word_q     <= '0;
      have_q     <= 1'b0;
      word_new_q <= 1'b0;
    end else if (load_en) begin
      word_q     <= fif.rd_data;
      have_q     <= 1'b1;
      word_new_q <= 1'b1;
    end else if (rd_done) begin
      word_new_q <= 1'b0;
      if (conv_mode == adcsri_pkg::CM_CONT_READ) begin
        have_q <= 1'b0;
      end
    end
  end

  // high pulse before a fresh result replaces an unread one
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pulse_cnt_q <= '0;
    end else if (load_en && word_new_q) begin
      pulse_cnt_q <= adcsri_pkg::t13_cycles(power_mode);
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 1'b1;
    end
  end

  assign rdy_level = !word_new_q || (pulse_cnt_q != '0);

  // ==========================================================
  // shared pin
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dly_cnt_q <= '0;
    end else if (rd_done) begin
      dly_cnt_q <= ready_delay_extend ? adcsri_pkg::RDY_DLY_EXT_CYC
                                      : adcsri_pkg::RDY_DLY_CYC;
    end else if (dly_cnt_q != '0) begin
      dly_cnt_q <= dly_cnt_q - 1'b1;
    end
  end

  // pin level by role
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dout_rdy_o <= 1'b1;
    end else begin
      case (state_q)
        SER_SHIFT: dout_rdy_o <= shift_q[adcsri_pkg::DATA_W-1];
        SER_HOLD: begin
          if (hold_until_deselect || (dly_cnt_q != '0)) begin
            dout_rdy_o <= shift_q[adcsri_pkg::DATA_W-1];
          end else begin
            dout_rdy_o <= rdy_level;
          end
        end
        default: dout_rdy_o <= rdy_level;
      endcase
    end
  end

  // drive only while selected
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      dout_rdy_oe <= 1'b0;
    end else begin
      dout_rdy_oe <= !cs_s_q[1];
    end
  end

  // ==========================================================
  // transaction spacing and filter restart
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gap_cnt_q     <= '0;
      spacing_error <= 1'b0;
    end else begin
      spacing_error <= cs_fall && (gap_cnt_q != '0);
      if (cs_rise) begin
        gap_cnt_q <= adcsri_pkg::min_mclk_cycles(power_mode);
      end else if (gap_cnt_q != '0) begin
        gap_cnt_q <= gap_cnt_q - 1'b1;
      end
    end
  end

  // restart accepted once the low level has lasted long enough
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sync_cnt_q     <= '0;
      filter_restart <= 1'b0;
    end else begin
      filter_restart <= !sync_s_q[1] &&
                        (sync_cnt_q == adcsri_pkg::min_mclk_cycles(power_mode) - 1'b1);
      if (sync_s_q[1]) begin
        sync_cnt_q <= '0;
      end else if (sync_cnt_q != '1) begin
        sync_cnt_q <= sync_cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // filter and buffer configuration
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      buf_enable_eff <= 1'b1;
      notch_60_en    <= 1'b0;
      rate_divider   <= '0;
    end else begin
      buf_enable_eff <= (gain_code != adcsri_pkg::GAIN_ONE) || !buf_disable_req;
      notch_60_en    <= first_notch_50hz && sixty_hz_notch_select;
      rate_divider   <= rate_select_field;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  property p_release;
    cs_rise |=> !dout_rdy_oe;
  endproperty
  a_release: assert property (p_release) else $error("pin driven after deselect");

  property p_not_ready;
    rd_done |=> !word_new_q ##1 (!word_new_q || $past(load_en));
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("ready kept after read");

  property p_once;
    (rd_done && (conv_mode == adcsri_pkg::CM_CONT_READ)) |=> !have_q;
  endproperty
  a_once: assert property (p_once) else $error("word kept in continuous read");

  property p_reread;
    (rd_done && (conv_mode != adcsri_pkg::CM_CONT_READ) && have_q) |=>
      have_q && (word_q == $past(word_q));
  endproperty
  a_reread: assert property (p_reread) else $error("word lost for re-read");

  property p_pulse;
    (load_en && word_new_q) |=> rdy_level [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("no high pulse before new result");

  property p_hold_lsb;
    (rd_done && hold_until_deselect) ##1 (!cs_s_q[1] && hold_until_deselect) [*2] |->
      (dout_rdy_o == shift_q[adcsri_pkg::DATA_W-1]);
  endproperty
  a_hold_lsb: assert property (p_hold_lsb) else $error("last bit not held");

  property p_ext_delay;
    (rd_done && ready_delay_extend) |=> (dly_cnt_q == adcsri_pkg::RDY_DLY_EXT_CYC);
  endproperty
  a_ext_delay: assert property (p_ext_delay) else $error("ready delay not stretched");

  property p_to_ready;
    ((state_q == SER_HOLD) && !hold_until_deselect && (dly_cnt_q == '0) && !cs_rise) |=>
      (dout_rdy_o == $past(rdy_level));
  endproperty
  a_to_ready: assert property (p_to_ready) else $error("pin not in ready role");

  property p_buf_on;
    (gain_code != adcsri_pkg::GAIN_ONE) |=> buf_enable_eff;
  endproperty
  a_buf_on: assert property (p_buf_on) else $error("buffers off at high gain");

  property p_buf_off;
    ((gain_code == adcsri_pkg::GAIN_ONE) && buf_disable_req) |=> !buf_enable_eff;
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer disable ignored");

  property p_notch;
    (first_notch_50hz && sixty_hz_notch_select) |=> notch_60_en;
  endproperty
  a_notch: assert property (p_notch) else $error("60 Hz notch missing");

  property p_restart;
    (filter_restart && $stable(power_mode)) |->
      (sync_cnt_q == adcsri_pkg::min_mclk_cycles(power_mode));
  endproperty
  a_restart: assert property (p_restart) else $error("restart accepted early");
endmodule

// ===== verif/adcsri_host.sv
`timescale 1ns/100ps
// host end of the serial link, link clock period 400 ns
module adcsri_host (
  input  wire logic        dout, // shared pin level
  input  wire logic        oe,   // shared pin drive enable
  output logic             sclk, // link clock, idle high
  output logic             cs_n, // chip select
  output logic             din,  // data to device
  output logic             got,  // pulse with a read word
  output logic [23:0]      word  // word read
);
  // ==========================================
  // idle levels
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
    got = 1'b0;
    word = 24'h0;
  end

  // one read of 24 bits; keep leaves the device selected
  task automatic frame(input logic [23:0] tx, input bit keep);
    cs_n = 1'b0;
    #400;
    for (int i = 23; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      #200;
      sclk = 1'b1;
      #100;
      word[i] = oe ? dout : 1'bx;
      #100;
    end
    got = 1'b1;
    #50;
    got = 1'b0;
    din = ~din; // released line does not keep its value
    if (!keep) begin
      release_cs();
    end
  endtask

  // deselect and leave the widest gap
  task automatic release_cs();
    cs_n = 1'b1;
    #1200;
  endtask

  // aborted frame followed by a select one clock later
  task automatic short_gap();
    cs_n = 1'b0;
    #150;
    cs_n = 1'b1;
    #50;
    cs_n = 1'b0;
    #150;
    release_cs();
  endtask
endmodule

// ===== verif/test_adc_serial_ready_interface.sv
`timescale 1ns/100ps
// bench for the serial result port
module test_adc_serial_ready_interface;
  logic clk_sys = 1'b0, resetn = 1'b0, sync_n = 1'b1, res_valid = 1'b0;
  logic [1:0] power_mode = 2'h2, conv_mode = 2'h0;
  logic hold_until_deselect = 1'b0, ready_delay_extend = 1'b0;
  logic [23:0] res_data = 24'h0, din_word, word, w;
  logic [2:0] gain_code = 3'h0;
  logic buf_disable_req = 1'b0, first_notch_50hz = 1'b0, sixty_hz_notch_select = 1'b0;
  logic [10:0] rate_select_field = 11'h0, rate_divider;
  logic sclk, cs_n, din, dout_rdy_o, dout_rdy_oe, res_ready, din_word_valid;
  logic spacing_error, filter_restart, buf_enable_eff, notch_60_en, got;
  int n_errors = 0, comparisons = 0, n_sp = 0, n_fr = 0, k;
  logic [23:0] q_dout[$], q_din[$];

  always #25 clk_sys = ~clk_sys;

  adcsri_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .din(din), .sync_n(sync_n), .dout_rdy_o(dout_rdy_o), .dout_rdy_oe(dout_rdy_oe),
    .power_mode(power_mode), .conv_mode(conv_mode), .hold_until_deselect(hold_until_deselect),
    .ready_delay_extend(ready_delay_extend), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .din_word(din_word), .din_word_valid(din_word_valid),
    .spacing_error(spacing_error), .filter_restart(filter_restart), .gain_code(gain_code),
    .buf_disable_req(buf_disable_req), .buf_enable_eff(buf_enable_eff),
    .first_notch_50hz(first_notch_50hz), .sixty_hz_notch_select(sixty_hz_notch_select),
    .notch_60_en(notch_60_en), .rate_select_field(rate_select_field),
    .rate_divider(rate_divider));
  adcsri_host u_host (.dout(dout_rdy_o), .oe(dout_rdy_oe), .sclk(sclk), .cs_n(cs_n),
    .din(din), .got(got), .word(word));

  // ==========================================
  // checking
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      n_errors++;
    end
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // take the oldest note whenever a result shows; sampled away from the launching edge
  always @(negedge clk_sys) begin
    if (din_word_valid === 1'b1) begin
      chk("din_word", din_word, q_din.size() ? q_din.pop_front() : 24'hx);
    end
    if (spacing_error === 1'b1) n_sp++;
    if (filter_restart === 1'b1) n_fr++;
  end
  always @(posedge got) chk("read", word, q_dout.size() ? q_dout.pop_front() : 24'hx);

  // offer one result word
  task automatic push(input logic [23:0] d);
    @(negedge clk_sys);
    res_valid = 1'b1;
    res_data = d;
    @(negedge clk_sys);
    res_valid = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask

  // read with expectations noted first
  task automatic rd(input logic [23:0] exp, input bit keep);
    w = 24'($urandom);
    q_dout.push_back(exp);
    q_din.push_back(w);
    u_host.frame(w, keep);
  endtask

  // ==========================================
  // main sequence
  initial begin
    void'($urandom(32'h9f90));
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    chk("rate", 24'(rate_divider), 24'h0);
    repeat (4) @(negedge clk_sys);
    for (k = 0; k < 20; k++) begin
      gain_code = k[3:1];
      buf_disable_req = k[0];
      {first_notch_50hz, sixty_hz_notch_select} = k[1:0];
      rate_select_field = 11'($urandom);
      repeat (2) @(negedge clk_sys);
      chk("buf", 24'(buf_enable_eff), 24'(gain_code != 3'h0 || !k[0]));
      chk("notch", 24'(notch_60_en), 24'(k[1:0] == 2'h3));
      chk("rate", 24'(rate_divider), 24'(rate_select_field));
    end
    w = 24'($urandom);
    push(w);
    rd(w, 1'b1);
    repeat (10) @(negedge clk_sys);
    chk("ready", 24'(dout_rdy_o), 24'h1);
    u_host.release_cs();
    chk("oe", 24'(dout_rdy_oe), 24'h0);
    rd(res_data, 1'b0);
    hold_until_deselect = 1'b1;
    conv_mode = 2'h2;
    res_data = 24'($urandom);
    push(res_data);
    rd(res_data, 1'b1);
    repeat (10) @(negedge clk_sys);
    chk("lsb", 24'(dout_rdy_o), 24'(res_data[0]));
    u_host.release_cs();
    ready_delay_extend = 1'b1;
    rd(24'h0, 1'b0);
    chk("gap", 24'(n_sp), 24'h0);
    power_mode = 2'h0;
    u_host.short_gap();
    chk("gap", 24'(n_sp), 24'h1);
    // low mode 30 long (taken), mid mode 10 long (too short), full mode 6 long (taken)
    for (k = 0; k < 3; k++) begin
      power_mode = 2'(k);
      @(negedge clk_sys);
      sync_n = 1'b0;
      repeat (k == 0 ? 30 : (k == 1 ? 10 : 6)) @(negedge clk_sys);
      sync_n = 1'b1;
      repeat (8) @(negedge clk_sys);
    end
    chk("restart", 24'(n_fr), 24'h2);
    for (k = 0; k < 18 && res_ready === 1'b1; k++) begin
      res_valid = 1'b1;
      res_data = 24'(k) + 24'h100;
      @(negedge clk_sys);
    end
    res_valid = 1'b0;
    @(negedge clk_sys);
    chk("full", 24'(res_ready), 24'h0);
    repeat (18 * 125) @(negedge clk_sys);
    rd(res_data, 1'b0);
    repeat (20) @(negedge clk_sys);
    end_of_test();
  end

  // cuts a hang short
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
endmodule
